/* logic/btb_pkg.sv */
package btb_pkg;

  // ==========================================================================
  // Widths and operand fields
  localparam int          BTB_DATA_W       = 16;
  localparam int          BTB_MASK_HI_LSB  = 8;
  localparam int          BTB_OFFSET_MSB   = 6;
  localparam logic [15:0] BTB_DATA_RST     = 16'h0000;
  localparam logic [9:0]  BTB_SHORT_PAD    = 10'h000;
  localparam logic [10:0] BTB_REG_PAD      = 11'h000;
  localparam logic [8:0]  BTB_SEXT_ONES    = 9'h1ff;
  localparam logic [8:0]  BTB_SEXT_ZEROS   = 9'h000;

  // Register code that names the hardware_loop_stack in the register_operand_field
  localparam logic [4:0]  BTB_HWS_CODE     = 5'h1f;
  // Base of the peripheral region reached by the short_io_address mode
  localparam logic [15:0] BTB_IO_BASE      = 16'hffc0;

  // ==========================================================================
  // Operand spaces
  localparam logic [1:0]  BTB_SPACE_REG    = 2'h0;
  localparam logic [1:0]  BTB_SPACE_DATA   = 2'h1;
  localparam logic [1:0]  BTB_SPACE_IO     = 2'h2;

  // ==========================================================================
  // Cycle and word costs
  localparam logic [3:0]  BTB_CYC_SET_SHORT = 4'h4;
  localparam logic [3:0]  BTB_CYC_SET_LONG  = 4'h6;
  localparam logic [3:0]  BTB_CYC_BR_S_TKN  = 4'ha;
  localparam logic [3:0]  BTB_CYC_BR_S_NOT  = 4'h8;
  localparam logic [3:0]  BTB_CYC_BR_L_TKN  = 4'hc;
  localparam logic [3:0]  BTB_CYC_BR_L_NOT  = 4'ha;
  localparam logic [3:0]  BTB_CYC_EXTRA     = BTB_CYC_BR_L_TKN - BTB_CYC_BR_L_NOT;
  localparam logic [3:0]  BTB_CNT_ONE       = 4'h1;
  localparam logic [3:0]  BTB_AGE_MAX       = 4'hf;
  localparam logic [1:0]  BTB_WORDS_SHORT   = 2'h2;
  localparam logic [1:0]  BTB_WORDS_LONG    = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    BITFIELD_TEST_SET_OP    = 2'h0,
    BRANCH_IF_BITS_CLEAR_OP = 2'h1,
    BRANCH_IF_BITS_SET_OP   = 2'h2
  } btb_op_t;

  typedef enum logic [2:0] {
    MODE_REGISTER_OPERAND       = 3'h0,
    MODE_PTR_TWO_INDEX          = 3'h1,
    MODE_STACK_INDEX            = 3'h2,
    MODE_SHORT_ABSOLUTE_DATA    = 3'h3,
    MODE_SHORT_IO               = 3'h4,
    MODE_LONG_ABSOLUTE          = 3'h5
  } btb_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_WAIT = 4'h4,
    ST_EVAL = 4'h8
  } btb_state_t;

  // ==========================================================================
  // Shared decoding
  function automatic logic btb_is_branch(input btb_op_t op);
    btb_is_branch = (op == BRANCH_IF_BITS_CLEAR_OP) || (op == BRANCH_IF_BITS_SET_OP);
  endfunction

  function automatic logic btb_half_zero(input logic [15:0] mask);
    btb_half_zero = (mask[15:BTB_MASK_HI_LSB] == 8'h00) || (mask[BTB_MASK_HI_LSB-1:0] == 8'h00);
  endfunction

  function automatic logic [3:0] btb_cycles(input btb_op_t op, input logic long_form,
                                            input logic taken);
    if (!btb_is_branch(op)) begin
      btb_cycles = long_form ? BTB_CYC_SET_LONG : BTB_CYC_SET_SHORT;
    end else if (long_form) begin
      btb_cycles = taken ? BTB_CYC_BR_L_TKN : BTB_CYC_BR_L_NOT;
    end else begin
      btb_cycles = taken ? BTB_CYC_BR_S_TKN : BTB_CYC_BR_S_NOT;
    end
  endfunction

endpackage

/* logic/btb_addr_gen.sv */
`timescale 1ns/1ps
module btb_addr_gen
  import btb_pkg::*;
(
  input  wire btb_mode_t   mode,
  input  wire logic [4:0]  register_operand_field,
  input  wire logic [5:0]  short_field,
  input  wire logic [15:0] ext_addr,
  input  wire logic [15:0] pointer_register_two,
  input  wire logic [15:0] stack_pointer,
  output logic [1:0]       space,
  output logic [15:0]      addr,
  output logic             long_form,
  output logic [1:0]       words,
  output logic             bad_operand
);

  // ==========================================================================
  // Operand address selection
  wire        is_reg   = (mode == MODE_REGISTER_OPERAND);
  wire        is_ptr   = (mode == MODE_PTR_TWO_INDEX);
  wire        is_sp    = (mode == MODE_STACK_INDEX);
  wire        is_sabs  = (mode == MODE_SHORT_ABSOLUTE_DATA);
  wire        is_io    = (mode == MODE_SHORT_IO);
  wire        is_long  = (mode == MODE_LONG_ABSOLUTE);
  wire [15:0] short_zx = {BTB_SHORT_PAD, short_field};

  assign addr = is_reg  ? {BTB_REG_PAD, register_operand_field} :
                is_ptr  ? pointer_register_two + short_zx :
                is_sp   ? stack_pointer - short_zx :
                is_sabs ? short_zx :                                   // see RQ8
                is_io   ? (BTB_IO_BASE | short_zx) :                   // see RQ9
                          ext_addr;

  assign space       = is_reg ? BTB_SPACE_REG : (is_io ? BTB_SPACE_IO : BTB_SPACE_DATA);
  assign long_form   = is_ptr | is_sp | is_long;
  assign words       = is_long ? BTB_WORDS_LONG : BTB_WORDS_SHORT;    // see RQ10
  assign bad_operand = (is_reg & (register_operand_field == BTB_HWS_CODE)) |   // see RQ3
                       ~(is_reg | is_ptr | is_sp | is_sabs | is_io | is_long);

endmodule

/* logic/btb_mask_eval.sv */
`timescale 1ns/1ps
module btb_mask_eval
  import btb_pkg::*;
(
  input  wire logic [15:0] mask,
  input  wire logic [15:0] data,
  output logic             all_set,
  output logic             all_clear,
  output logic [15:0]      set_value
);

  // ==========================================================================
  // Test of the selected bits and the set result
  wire [15:0] picked = data & mask;

  assign all_set   = (picked == mask);                                 // see RQ1
  assign all_clear = (picked == BTB_DATA_RST);                         // see RQ4
  assign set_value = data | mask;                                      // see RQ2

endmodule

/* logic/btb_exec.sv */
`timescale 1ns/1ps
// ============================================================================
// Notes on behaviour
// RQ1: Test-and-set sets carry when all mask-selected bits are one, else clears it.
// RQ2: Test-and-set then forces selected bits to one, leaving others unchanged.
// RQ3: Hardware loop stack as register operand is rejected as invalid.
// RQ4: Branch-if-clear: all selected zero sets carry and branches, else clears carry.
// RQ5: Branch-if-set: all selected one sets carry and branches, else clears carry.
// RQ6: Branch mask is 16 bits with one whole byte zero; others rejected.
// RQ7: Branch target is program counter plus sign-extended 7-bit offset.
// RQ8: Short absolute data mode addresses memory with a 6-bit absolute address.
// RQ9: Short I/O mode uses a 6-bit address inside the peripheral region.
// RQ10: Long absolute branch is 3 words, 12/10 cycles; other forms 10/8. Pointer-two and stack index branches here also take 12/10.
// RQ11: Larger branch count when taken, smaller count when not taken.
// RQ12: Carry comes from the operand as read, before any modification.
module btb_exec
  import btb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire btb_op_t     op,
  input  wire btb_mode_t   mode,
  input  wire logic [15:0] mask,
  input  wire logic [4:0]  register_operand_field,
  input  wire logic [5:0]  short_field,
  input  wire logic [15:0] ext_addr,
  input  wire logic [6:0]  relative_branch_offset,
  input  wire logic [15:0] pc_in,
  input  wire logic [15:0] pointer_register_two,
  input  wire logic [15:0] stack_pointer,
  input  wire logic [15:0] rd_data,
  output logic             busy,
  output logic             rd_req,
  output logic [1:0]       operand_space,
  output logic [15:0]      operand_addr,
  output logic             wr_en,
  output logic [15:0]      wr_data,
  output logic             carry_we,
  output logic             carry_val,
  output logic             branch_taken,
  output logic [15:0]      branch_target,
  output logic [1:0]       instr_words,
  output logic             done,
  output logic             illegal
);

  // ==========================================================================
  // Reset release
  logic rst_meta_q;
  logic rst_sync_n_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q   <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q   <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // ==========================================================================
  // Declarations
  btb_state_t  state_q;
  btb_state_t  state_d;
  btb_op_t     op_q;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic [15:0] mask_q;
  logic [15:0] opnd_q;
  logic [15:0] set_q;
  logic        cond_q;
  logic        long_q;
  logic        busy_q;
  logic        rd_req_q;
  logic [1:0]  space_q;
  logic [15:0] addr_q;
  logic        wr_en_q;
  logic [15:0] wr_data_q;
  logic        carry_we_q;
  logic        carry_val_q;
  logic        taken_q;
  logic [15:0] target_q;
  logic [1:0]  words_q;
  logic        done_q;
  logic        illegal_q;
  logic [15:0] pc_q;
  logic [6:0]  off_q;
  logic [3:0]  age_q;

  logic [1:0]  ag_space;
  logic [15:0] ag_addr;
  logic        ag_long;
  logic [1:0]  ag_words;
  logic        ag_bad;
  logic        me_all_set;
  logic        me_all_clear;
  logic [15:0] me_set_value;

  // ==========================================================================
  // Operand address and mask test
  btb_addr_gen u_addr_gen (
    .mode                   (mode),
    .register_operand_field (register_operand_field),
    .short_field            (short_field),
    .ext_addr               (ext_addr),
    .pointer_register_two   (pointer_register_two),
    .stack_pointer          (stack_pointer),
    .space                  (ag_space),
    .addr                   (ag_addr),
    .long_form              (ag_long),
    .words                  (ag_words),
    .bad_operand            (ag_bad)
  );

  // Tests the word as it arrives, so nothing written can bias the carry
  btb_mask_eval u_mask_eval (
    .mask      (mask_q),
    .data      (rd_data),
    .all_set   (me_all_set),
    .all_clear (me_all_clear),
    .set_value (me_set_value)
  );

  // ==========================================================================
  // Control decode
  wire        accept   = start & (state_q == ST_IDLE);
  wire        bad_mask = btb_is_branch(op) & ~btb_half_zero(mask);          // see RQ6
  wire        reject   = accept & (ag_bad | bad_mask);                      // see RQ3
  wire        launch   = accept & ~reject;
  wire        capture  = (state_q == ST_WAIT);
  wire        fin      = (state_q == ST_EVAL) & (cnt_q == BTB_CNT_ONE);
  wire        cond     = (op_q == BRANCH_IF_BITS_CLEAR_OP) ? me_all_clear :  // see RQ4
                                                            me_all_set;     // see RQ1
  wire        taken    = btb_is_branch(op_q) & cond;
  wire [15:0] sext_off = {relative_branch_offset[BTB_OFFSET_MSB] ? BTB_SEXT_ONES :
                          BTB_SEXT_ZEROS, relative_branch_offset};
  wire [3:0]  base_cyc = btb_cycles(op, ag_long, 1'b0);

  // Taken branches learn their extra cycles once the operand is known
  assign cnt_d = launch             ? base_cyc - BTB_CNT_ONE :
                 (capture & taken)  ? cnt_q - BTB_CNT_ONE + BTB_CYC_EXTRA :  // see RQ11
                 (state_q != ST_IDLE) ? cnt_q - BTB_CNT_ONE :
                                      cnt_q;

  always_comb begin
    case (state_q)
      ST_IDLE: state_d = launch ? ST_READ : ST_IDLE;
      ST_READ: state_d = ST_WAIT;
      ST_WAIT: state_d = ST_EVAL;
      ST_EVAL: state_d = fin ? ST_IDLE : ST_EVAL;
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      busy_q  <= (state_d != ST_IDLE);
    end
  end

  // ==========================================================================
  // Launch: latch the instruction and issue the operand read
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      op_q     <= BITFIELD_TEST_SET_OP;
      mask_q   <= BTB_DATA_RST;
      long_q   <= 1'b0;
      space_q  <= BTB_SPACE_REG;
      addr_q   <= BTB_DATA_RST;
      target_q <= BTB_DATA_RST;
      words_q  <= BTB_WORDS_SHORT;
      rd_req_q <= 1'b0;
    end else begin
      rd_req_q <= launch;
      if (launch) begin
        op_q     <= op;
        mask_q   <= mask;
        long_q   <= ag_long;
        space_q  <= ag_space;
        addr_q   <= ag_addr;                                                // see RQ8
        target_q <= pc_in + sext_off;                                       // see RQ7
        words_q  <= ag_words;                                               // see RQ10
      end
    end
  end

  // ==========================================================================
  // Capture the operand as read
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      opnd_q <= BTB_DATA_RST;
      set_q  <= BTB_DATA_RST;
      cond_q <= 1'b0;
    end else if (capture) begin
      opnd_q <= rd_data;                                                    // see RQ12
      set_q  <= me_set_value;                                               // see RQ2
      cond_q <= cond;                                                       // see RQ5
    end
  end

  // ==========================================================================
  // Results, flags presented for one cycle with done; wr_data holds until the next finish
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      done_q      <= 1'b0;
      illegal_q   <= 1'b0;
      carry_we_q  <= 1'b0;
      carry_val_q <= 1'b0;
      taken_q     <= 1'b0;
      wr_en_q     <= 1'b0;
      wr_data_q   <= BTB_DATA_RST;
    end else begin
      done_q      <= fin | reject;
      illegal_q   <= reject;
      carry_we_q  <= fin;
      carry_val_q <= fin & cond_q;
      taken_q     <= fin & cond_q & btb_is_branch(op_q);                    // see RQ4
      wr_en_q     <= fin & (op_q == BITFIELD_TEST_SET_OP);                  // see RQ2
      if (fin) begin
        wr_data_q <= set_q;
      end
    end
  end

  // ==========================================================================
  // Checking aids
  always_ff @(posedge clock or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      pc_q  <= BTB_DATA_RST;
      off_q <= 7'h00;
      age_q <= 4'h0;
    end else begin
      if (launch) begin
        pc_q  <= pc_in;
        off_q <= relative_branch_offset;
      end
      age_q <= launch ? BTB_CNT_ONE : ((age_q != BTB_AGE_MAX) ? age_q + BTB_CNT_ONE : age_q);
    end
  end

  // ==========================================================================
  // Outputs
  assign busy          = busy_q;
  assign rd_req        = rd_req_q;
  assign operand_space = space_q;
  assign operand_addr  = addr_q;
  assign wr_en         = wr_en_q;
  assign wr_data       = wr_data_q;
  assign carry_we      = carry_we_q;
  assign carry_val     = carry_val_q;
  assign branch_taken  = taken_q;
  assign branch_target = target_q;
  assign instr_words   = words_q;
  assign done          = done_q;
  assign illegal       = illegal_q;

  // ==========================================================================
  // Assertions
  property p_set_carry;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (carry_we_q && op_q == BITFIELD_TEST_SET_OP) |-> carry_val_q == ((opnd_q & mask_q) == mask_q);
  endproperty
  a_set_carry: assert property (p_set_carry) else $error("test-and-set carry wrong"); // see RQ1

  property p_set_write;
    @(posedge clock) disable iff (!rst_sync_n_q)
    wr_en_q |-> (wr_data_q == (opnd_q | mask_q)) && (operand_addr == $past(operand_addr, 3));
  endproperty
  a_set_write: assert property (p_set_write) else $error("set result wrong"); // see RQ2

  property p_hws_reject;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (accept && mode == MODE_REGISTER_OPERAND && register_operand_field == BTB_HWS_CODE)
      |=> illegal_q && done_q && !rd_req_q ##1 !busy_q;
  endproperty
  a_hws_reject: assert property (p_hws_reject) else $error("loop stack operand accepted"); // see RQ3

  property p_clear_branch;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (carry_we_q && op_q == BRANCH_IF_BITS_CLEAR_OP)
      |-> (carry_val_q == ((opnd_q & mask_q) == 16'h0000)) && (taken_q == carry_val_q);
  endproperty
  a_clear_branch: assert property (p_clear_branch) else $error("clear branch wrong"); // see RQ4

  property p_bits_set_branch;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (carry_we_q && op_q == BRANCH_IF_BITS_SET_OP)
      |-> (carry_val_q == ((opnd_q & mask_q) == mask_q)) && (taken_q == carry_val_q);
  endproperty
  a_bits_set_branch: assert property (p_bits_set_branch) else $error("set branch wrong"); // see RQ5

  property p_mask_shape;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (accept && btb_is_branch(op) && mask[15:8] != 8'h00 && mask[7:0] != 8'h00)
      |=> illegal_q && !rd_req_q;
  endproperty
  a_mask_shape: assert property (p_mask_shape) else $error("bad branch mask accepted"); // see RQ6

  property p_target;
    @(posedge clock) disable iff (!rst_sync_n_q)
    taken_q |-> branch_target == pc_q + {{9{off_q[6]}}, off_q};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong"); // see RQ7

  property p_short_abs;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (launch && mode == MODE_SHORT_ABSOLUTE_DATA)
      |=> rd_req_q && operand_space == BTB_SPACE_DATA && operand_addr == {10'h000, $past(short_field)};
  endproperty
  a_short_abs: assert property (p_short_abs) else $error("short address wrong"); // see RQ8

  property p_short_io;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (launch && mode == MODE_SHORT_IO)
      |=> operand_space == BTB_SPACE_IO && operand_addr == (16'hffc0 | {10'h000, $past(short_field)});
  endproperty
  a_short_io: assert property (p_short_io) else $error("I/O address wrong"); // see RQ9

  property p_long_cost;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (done_q && !illegal_q && btb_is_branch(op_q))
      |-> (long_q ? age_q == (taken_q ? 4'hc : 4'ha) : age_q == (taken_q ? 4'ha : 4'h8))
          && (instr_words == ((operand_space != BTB_SPACE_REG && !long_q) ? 2'h2 : instr_words));
  endproperty
  a_long_cost: assert property (p_long_cost) else $error("branch cycle count wrong"); // see RQ10

  property p_taken_cost;
    @(posedge clock) disable iff (!rst_sync_n_q)
    (done_q && !illegal_q) |-> age_q == btb_cycles(op_q, long_q, taken_q) && !busy_q;
  endproperty
  a_taken_cost: assert property (p_taken_cost) else $error("cycle count wrong"); // see RQ11

  property p_orig_operand;
    @(posedge clock) disable iff (!rst_sync_n_q)
    wr_en_q |-> carry_val_q == ((opnd_q & mask_q) == mask_q) && ((wr_data_q & mask_q) == mask_q);
  endproperty
  a_orig_operand: assert property (p_orig_operand) else $error("carry not from original"); // see RQ12

endmodule

/* test/btb_exec_tb.sv */
`timescale 1ns/1ps
module testbench
  import btb_pkg::*;
;
  logic        clock;
  logic        rstn;
  logic        start;
  btb_op_t     op;
  btb_mode_t   mode;
  logic [15:0] mask;
  logic [4:0]  register_operand_field;
  logic [5:0]  short_field;
  logic [15:0] ext_addr;
  logic [6:0]  relative_branch_offset;
  logic [15:0] pc_in;
  logic [15:0] pointer_register_two;
  logic [15:0] stack_pointer;
  logic [15:0] rd_data;
  logic        busy;
  logic        rd_req;
  logic [1:0]  operand_space;
  logic [15:0] operand_addr;
  logic        wr_en;
  logic [15:0] wr_data;
  logic        carry_we;
  logic        carry_val;
  logic        branch_taken;
  logic [15:0] branch_target;
  logic [1:0]  instr_words;
  logic        done;
  logic        illegal;
  int          fails;
  int          comparisons;
  int          n_cyc;
  int          ticks = 0;
  logic        seen_rd;
  logic        rd_now;
  logic        busy_first;
  logic [4:0]  cap;

  btb_exec uut (.clock(clock), .rstn(rstn), .start(start), .op(op), .mode(mode), .mask(mask),
    .register_operand_field(register_operand_field), .short_field(short_field),
    .ext_addr(ext_addr), .relative_branch_offset(relative_branch_offset), .pc_in(pc_in),
    .pointer_register_two(pointer_register_two), .stack_pointer(stack_pointer),
    .rd_data(rd_data), .busy(busy), .rd_req(rd_req), .operand_space(operand_space),
    .operand_addr(operand_addr), .wr_en(wr_en), .wr_data(wr_data), .carry_we(carry_we),
    .carry_val(carry_val), .branch_taken(branch_taken), .branch_target(branch_target),
    .instr_words(instr_words), .done(done), .illegal(illegal));

  // ==========================================================================
  // Clock and timeout
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    ticks <= ticks + 1;
    if (ticks == 2000) begin
      fails = fails + 1;
      summarize();
    end
  end

  // ==========================================================================
  // Checking and reporting
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // One instruction; operand data is valid only in the cycle after rd_req
  task automatic run(input btb_op_t o, input btb_mode_t m, input logic [15:0] mk,
                     input logic [4:0] rf, input logic [5:0] sf, input logic [15:0] ea,
                     input logic [6:0] of, input logic [15:0] opnd);
    @(posedge clock);
    start <= 1'b1;
    op <= o;
    mode <= m;
    mask <= mk;
    register_operand_field <= rf;
    short_field <= sf;
    ext_addr <= ea;
    relative_branch_offset <= of;
    @(posedge clock);
    start <= 1'b0;
    seen_rd = 1'b0;
    rd_now = 1'b0;
    n_cyc = 0;
    for (int k = 0; k < 16 && n_cyc == 0; k++) begin
      if (k > 0) @(posedge clock);
      rd_data <= rd_now ? opnd : ~opnd;
      #1;
      rd_now = (rd_req === 1'b1);
      if (rd_now) seen_rd = 1'b1;
      if (k == 0) busy_first = busy;
      if (done === 1'b1) begin
        n_cyc = k + 1;
        cap = {carry_we, carry_val, wr_en, branch_taken, illegal};
      end
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_set();
    run(BITFIELD_TEST_SET_OP, MODE_REGISTER_OPERAND, 16'h00f0, 5'h03, 6'h00, 16'h0, 7'h0,
        16'h12f4);
    chk(16'(n_cyc), 16'h0004);
    chk({11'h0, cap}, 16'h001c);
    chk(wr_data, 16'h12f4);
    chk({12'h0, operand_space, instr_words}, 16'h0002);
    run(BITFIELD_TEST_SET_OP, MODE_SHORT_ABSOLUTE_DATA, 16'h0ff0, 5'h00, 6'h2a, 16'h0, 7'h0,
        16'ha50f);
    chk({11'h0, cap}, 16'h0014);
    chk(wr_data, 16'hafff);
    chk(operand_addr, 16'h002a);
    chk({14'h0, operand_space}, 16'h0001);
    $display("test set done");
  endtask

  task automatic t_clear();
    run(BRANCH_IF_BITS_CLEAR_OP, MODE_REGISTER_OPERAND, 16'h0081, 5'h01, 6'h00, 16'h0, 7'h70,
        16'h7f7e);
    chk(16'(n_cyc), 16'h000a);
    chk({11'h0, cap}, 16'h001a);
    chk(branch_target, 16'h00f0);
    run(BRANCH_IF_BITS_CLEAR_OP, MODE_REGISTER_OPERAND, 16'h0081, 5'h01, 6'h00, 16'h0, 7'h70,
        16'h0001);
    chk(16'(n_cyc), 16'h0008);
    chk({11'h0, cap}, 16'h0010);
    $display("test clear done");
  endtask

  task automatic t_set_io();
    run(BRANCH_IF_BITS_SET_OP, MODE_SHORT_IO, 16'h3c00, 5'h00, 6'h05, 16'h0, 7'h0f, 16'h3c00);
    chk(16'(n_cyc), 16'h000a);
    chk({11'h0, cap}, 16'h001a);
    chk(operand_addr, 16'hffc5);
    chk({14'h0, operand_space}, 16'h0002);
    chk(branch_target, 16'h010f);
    $display("test io done");
  endtask

  task automatic t_long();
    run(BRANCH_IF_BITS_SET_OP, MODE_LONG_ABSOLUTE, 16'h0003, 5'h00, 6'h00, 16'h4321, 7'h01,
        16'h0002);
    chk(16'(n_cyc), 16'h000a);
    chk({11'h0, cap}, 16'h0010);
    chk({14'h0, instr_words}, 16'h0003);
    chk(operand_addr, 16'h4321);
    run(BRANCH_IF_BITS_SET_OP, MODE_LONG_ABSOLUTE, 16'h0003, 5'h00, 6'h00, 16'h4321, 7'h01,
        16'h0003);
    chk(16'(n_cyc), 16'h000c);
    chk({11'h0, cap}, 16'h001a);
    $display("test long done");
  endtask

  task automatic t_refused();
    run(BITFIELD_TEST_SET_OP, MODE_REGISTER_OPERAND, 16'h0001, BTB_HWS_CODE, 6'h00, 16'h0,
        7'h0, 16'h0);
    chk({9'h0, 16'(n_cyc) == 16'h1, seen_rd, cap}, 16'h0041);
    run(BRANCH_IF_BITS_CLEAR_OP, MODE_REGISTER_OPERAND, 16'h0101, 5'h02, 6'h00, 16'h0, 7'h0,
        16'h0);
    chk({9'h0, 16'(n_cyc) == 16'h1, seen_rd, cap}, 16'h0041);
    run(BRANCH_IF_BITS_SET_OP, MODE_REGISTER_OPERAND, 16'hff00, 5'h02, 6'h00, 16'h0, 7'h0,
        16'hff00);
    chk(16'(n_cyc), 16'h000a);
    $display("test refused done");
  endtask

  task automatic t_modes();
    run(BITFIELD_TEST_SET_OP, MODE_PTR_TWO_INDEX, 16'h8001, 5'h00, 6'h05, 16'h0, 7'h0,
        16'h0001);
    chk({11'h0, cap}, 16'h0014);
    chk(wr_data, 16'h8001);
    chk(operand_addr, 16'h0205);
    chk({14'h0, seen_rd, busy_first}, 16'h0003);
    run(BRANCH_IF_BITS_CLEAR_OP, MODE_STACK_INDEX, 16'h00ff, 5'h00, 6'h04, 16'h0, 7'h3f,
        16'hff00);
    chk(16'(n_cyc), 16'h000c);
    chk({11'h0, cap}, 16'h001a);
    chk(operand_addr, 16'h02fc);
    chk({14'h0, instr_words}, 16'h0002);
    chk(branch_target, 16'h013f);
    run(BRANCH_IF_BITS_SET_OP, btb_mode_t'(3'h6), 16'h0001, 5'h00, 6'h00, 16'h0, 7'h0,
        16'h0001);
    chk({9'h0, 16'(n_cyc) == 16'h1, seen_rd, cap}, 16'h0041);
    chk({15'h0, busy_first}, 16'h0000);
    $display("test modes done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    rstn = 1'b0;
    start = 1'b0;
    op = BITFIELD_TEST_SET_OP;
    mode = MODE_REGISTER_OPERAND;
    mask = 16'h0000;
    register_operand_field = 5'h00;
    short_field = 6'h00;
    ext_addr = 16'h0000;
    relative_branch_offset = 7'h00;
    pc_in = 16'h0100;
    pointer_register_two = 16'h0200;
    stack_pointer = 16'h0300;
    rd_data = 16'h0000;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    t_set();
    t_clear();
    t_set_io();
    t_long();
    t_refused();
    t_modes();
    summarize();
  end
endmodule
